// ### rtl/ocl_pkg.sv
package ocl_pkg;
  // system clock period in ns, for reference only
  localparam int          SYS_CLK_PERIOD_NS = 4;
  // rc reference periods without an oscillator edge before loss is declared
  localparam int          LOSS_PERIODS      = 9;
  localparam int          LOSS_CNT_W        = 4;
  // system clock outputs are the source divided by this ratio
  localparam int          DIV_RATIO         = 4;
  // observation source select codes
  localparam int          OBS_SEL_W         = 2;
  localparam logic [1:0]  OBS_SRC_OSC       = 2'h0;
  localparam logic [1:0]  OBS_SRC_RC        = 2'h1;
  localparam logic [1:0]  OBS_SRC_SYS       = 2'h2;
  localparam logic [1:0]  OBS_SRC_MCU       = 2'h3;
  // reset values
  localparam logic        RST_ERROR_N       = 1'h1;
  localparam logic [3:0]  RST_LOSS_CNT      = 4'h0;
endpackage

// ### rtl/ocl_clock_loss_monitor.sv
// Function
// - rc reference clock logic supervises the oscillator clock for stopping.
// - nine rc periods with no oscillator toggle declare a clock-stop loss.
// - on loss, reference switches to rc clock only when switch enable set.
// - error output is driven low while the loss condition exists.
// - both system clock outputs are their system clocks divided by four.
// - system clock outputs are hardwired to their sources, no mux.
// - each observation output shows one selectable internal clock source.
// - peripheral clock output only works while pad receive active is set.
`timescale 1ns/1ps
`default_nettype none
module ocl_clock_loss_monitor (
  // clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     nrst,
  // monitored and reference clocks, asynchronous
  input  wire logic                     main_osc_clock,
  input  wire logic                     rc_ref_clock,
  input  wire logic                     main_system_clock,
  input  wire logic                     mcu_system_clock,
  input  wire logic                     periph_clock,
  // configuration, same clock domain
  input  wire logic                     loss_switch_enable,
  input  wire logic [ocl_pkg::OBS_SEL_W-1:0] obs_sel_a,
  input  wire logic [ocl_pkg::OBS_SEL_W-1:0] obs_sel_b,
  input  wire logic [ocl_pkg::OBS_SEL_W-1:0] obs_sel_mcu,
  input  wire logic                     pad_receive_active,
  // loss status
  output logic                          clock_loss,
  output logic                          ref_sel_rc,
  output logic                          error_out_n,
  // clock outputs
  output logic                          sys_clock_div_out,
  output logic                          mcu_sys_clock_div_out,
  output logic                          observe_clock_out_a,
  output logic                          observe_clock_out_b,
  output logic                          mcu_observe_clock_out,
  output logic                          periph_clock_out
);
  import ocl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [4:0]            s1;     // first sync stage, read only by s2
    logic [4:0]            s2;     // second sync stage
    logic [3:0]            d;      // delayed s2 for edge detection
    logic [LOSS_CNT_W-1:0] cnt;
    logic                  loss;
    logic                  ref_rc;
    logic                  err_n;
    logic                  div_sys;
    logic                  div_mcu;
    logic                  sys_out;
    logic                  mcu_out;
    logic                  obs_a;
    logic                  obs_b;
    logic                  obs_m;
    logic                  per_out;
  } ocl_state_t;

  ocl_state_t st;
  ocl_state_t next_st;

  // bit positions inside the sync vectors
  localparam int I_OSC = 0;
  localparam int I_RC  = 1;
  localparam int I_SYS = 2;
  localparam int I_MCU = 3;
  localparam int I_PER = 4;
  localparam logic [LOSS_CNT_W-1:0] LOSS_LIMIT = LOSS_CNT_W'(LOSS_PERIODS);
  localparam logic                  DIV_LAST   = 1'(DIV_RATIO / 2 - 1);

  // rising edge of a synchronised level
  function automatic logic ocl_rise(input logic now, input logic prev);
    ocl_rise = now & ~prev;
  endfunction

  // observation source mux, shared by all three observation pins
  function automatic logic ocl_obs(input logic [1:0] sel, input logic [3:0] src);
    logic r;
    r = 1'b0;
    unique case (sel)
      OBS_SRC_OSC: r = src[I_OSC];
      OBS_SRC_RC:  r = src[I_RC];
      OBS_SRC_SYS: r = src[I_SYS];
      OBS_SRC_MCU: r = src[I_MCU];
    endcase
    ocl_obs = r;
  endfunction

  logic osc_rise;
  logic rc_rise;
  logic sys_rise;
  logic mcu_rise;
  assign osc_rise = ocl_rise(st.s2[I_OSC], st.d[I_OSC]);
  assign rc_rise  = ocl_rise(st.s2[I_RC], st.d[I_RC]);
  assign sys_rise = ocl_rise(st.s2[I_SYS], st.d[I_SYS]);
  assign mcu_rise = ocl_rise(st.s2[I_MCU], st.d[I_MCU]);

  ////////////////////////////////////////////////////////////////////////////
  // next state; the fast sys_clk samples all five slow clocks so edges are seen
  always_comb begin
    next_st    = st;
    next_st.s1 = {periph_clock, mcu_system_clock, main_system_clock,
                  rc_ref_clock, main_osc_clock};
    next_st.s2 = st.s1;
    next_st.d  = st.s2[3:0];
    // oscillator edge wins over rc edge so a live clock never trips
    if (osc_rise) begin
      next_st.cnt  = RST_LOSS_CNT;
      next_st.loss = 1'b0;
    end else if (rc_rise && st.cnt != LOSS_LIMIT) begin
      next_st.cnt = st.cnt + LOSS_CNT_W'(1);
      if (st.cnt + LOSS_CNT_W'(1) == LOSS_LIMIT) begin
        next_st.loss = 1'b1;
      end
    end
    // switch-over follows the loss only when enabled
    next_st.ref_rc = next_st.loss & loss_switch_enable;
    next_st.err_n  = ~next_st.loss;
    // divide by four: toggle every second rising edge, fixed sources
    if (sys_rise) begin
      next_st.div_sys = (st.div_sys == DIV_LAST) ? 1'b0 : ~st.div_sys;
      if (st.div_sys == DIV_LAST) begin
        next_st.sys_out = ~st.sys_out;
      end
    end
    if (mcu_rise) begin
      next_st.div_mcu = (st.div_mcu == DIV_LAST) ? 1'b0 : ~st.div_mcu;
      if (st.div_mcu == DIV_LAST) begin
        next_st.mcu_out = ~st.mcu_out;
      end
    end
    // observation pins are debug only, not meant as clean clocks
    next_st.obs_a = ocl_obs(obs_sel_a, st.s2[3:0]);
    next_st.obs_b = ocl_obs(obs_sel_b, st.s2[3:0]);
    next_st.obs_m = ocl_obs(obs_sel_mcu, st.s2[3:0]);
    // without the receive path enabled the pad cannot return its clock
    next_st.per_out = st.s2[I_PER] & pad_receive_active;
  end

  // single state register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st       <= '0;
      st.err_n <= RST_ERROR_N;
    end else begin
      st <= next_st;
    end
  end

  assign clock_loss            = st.loss;
  assign ref_sel_rc            = st.ref_rc;
  assign error_out_n           = st.err_n;
  assign sys_clock_div_out     = st.sys_out;
  assign mcu_sys_clock_div_out = st.mcu_out;
  assign observe_clock_out_a   = st.obs_a;
  assign observe_clock_out_b   = st.obs_b;
  assign mcu_observe_clock_out = st.obs_m;
  assign periph_clock_out      = st.per_out;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence s_rc_step;
    rc_rise && !osc_rise && st.cnt != LOSS_LIMIT;
  endsequence

  a_count_rc_step: assert property (s_rc_step |=> st.cnt == $past(st.cnt) + 4'h1)
    else $error("rc period not counted");
  a_loss_at_nine: assert property (
    (s_rc_step and st.cnt == 4'h8) |=> (clock_loss && st.cnt == 4'h9))
    else $error("loss not raised on ninth rc period");
  a_no_early_loss: assert property ($rose(clock_loss) |-> st.cnt == 4'h9)
    else $error("loss raised before nine periods");
  a_switch_gated: assert property (ref_sel_rc == (clock_loss && $past(loss_switch_enable)))
    else $error("reference switch mismatch");
  a_error_pin_low: assert property (error_out_n == !clock_loss)
    else $error("error pin does not follow loss");
  a_osc_restart: assert property (osc_rise |=> (st.cnt == 4'h0 && !clock_loss))
    else $error("oscillator edge did not restart count");
  // loss flag and period counter only move on their own edges
  a_loss_holds: assert property ((clock_loss && !osc_rise) |=> clock_loss)
    else $error("loss dropped without oscillator edge");
  a_count_still: assert property ((!rc_rise && !osc_rise) |=> $stable(st.cnt))
    else $error("rc period count moved without an rc edge");

  // dividers toggle on every second source edge and follow only their own source
  a_div_toggle: assert property (
    (sys_rise && st.div_sys == DIV_LAST) |=> sys_clock_div_out != $past(sys_clock_div_out))
    else $error("system clock divider did not toggle");
  a_div_hold: assert property (
    (sys_rise && st.div_sys != DIV_LAST) |=> $stable(sys_clock_div_out))
    else $error("system clock divider toggled early");
  a_mcu_toggle: assert property (
    (mcu_rise && st.div_mcu == DIV_LAST) |=> $changed(mcu_sys_clock_div_out))
    else $error("mcu clock divider did not toggle");
  a_mcu_div: assert property (!mcu_rise |=> $stable(mcu_sys_clock_div_out))
    else $error("mcu divider moved without its source");
  a_sys_source: assert property (!sys_rise |=> $stable(sys_clock_div_out))
    else $error("system divider moved without its source");

  // observation and pad paths; obs pins may glitch, they are debug only
  a_obs_select: assert property (
    (obs_sel_a == OBS_SRC_RC) |=> observe_clock_out_a == $past(st.s2[I_RC]))
    else $error("observation mux wrong source");
  a_obs_b_select: assert property (
    (obs_sel_b == OBS_SRC_OSC) |=> observe_clock_out_b == $past(st.s2[I_OSC]))
    else $error("second observation mux wrong source");
  a_obs_m_select: assert property (
    (obs_sel_mcu == OBS_SRC_MCU) |=> mcu_observe_clock_out == $past(st.s2[I_MCU]))
    else $error("mcu observation mux wrong source");
  a_pad_gate: assert property (!pad_receive_active |=> !periph_clock_out)
    else $error("peripheral clock out without receive active");
  a_pad_pass: assert property (
    pad_receive_active |=> periph_clock_out == $past(st.s2[I_PER]))
    else $error("peripheral clock not passed with receive active");
endmodule
`default_nettype wire

// ### verification/ocl_pmic_model.sv
`timescale 1ns/1ps
`default_nettype none
module ocl_pmic_model (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  // fault line from the device
  input  wire logic       error_out_n,
  // count of falling fault edges, each one a recovery request
  output logic      [7:0] n_faults
);
  logic err_q;
  // recovery is left to this side; obs pins never clock it
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      err_q    <= 1'b1;
      n_faults <= 8'h00;
    end else begin
      err_q <= error_out_n;
      if (err_q && !error_out_n) n_faults <= n_faults + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ### verification/test_ocl_clock_loss_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module test_ocl_clock_loss_monitor;
  logic       sys_clk, nrst, osc, rc, sysc, mcuc, per, en, pra;
  logic [1:0] sa, sb, sm;
  logic       loss, refrc, errn, dv, mdv, oa, ob, om, po;
  logic [7:0] nf;
  bit         osc_on, rc_on, sys_on, mcu_on, per_on;
  int         fails, n_compared;

  ocl_clock_loss_monitor u_ocl_clock_loss_monitor (.sys_clk(sys_clk), .nrst(nrst),
    .main_osc_clock(osc), .rc_ref_clock(rc), .main_system_clock(sysc),
    .mcu_system_clock(mcuc), .periph_clock(per), .loss_switch_enable(en),
    .obs_sel_a(sa), .obs_sel_b(sb), .obs_sel_mcu(sm), .pad_receive_active(pra),
    .clock_loss(loss), .ref_sel_rc(refrc), .error_out_n(errn),
    .sys_clock_div_out(dv), .mcu_sys_clock_div_out(mdv), .observe_clock_out_a(oa),
    .observe_clock_out_b(ob), .mcu_observe_clock_out(om), .periph_clock_out(po));
  ocl_pmic_model u_ocl_pmic_model (.sys_clk(sys_clk), .nrst(nrst), .error_out_n(errn),
    .n_faults(nf));

  //////////////////////////////////////////////////////////////////////////////
  // slow source clocks; each holds its level while stopped
  // toggles land one step after a sys_clk edge so no sample races them
  initial forever begin repeat (3) @(posedge sys_clk); #1; if (osc_on) osc = ~osc; end
  initial forever begin repeat (5) @(posedge sys_clk); #1; if (rc_on) rc = ~rc; end
  initial forever begin repeat (4) @(posedge sys_clk); #1; if (sys_on) sysc = ~sysc; end
  initial forever begin repeat (4) @(posedge sys_clk); #1; if (mcu_on) mcuc = ~mcuc; end
  initial forever begin repeat (3) @(posedge sys_clk); #1; if (per_on) per = ~per; end
  initial begin sys_clk = 1'b0; forever #2 sys_clk = ~sys_clk; end

  task automatic results();
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // bounded wait for the loss flag; running out ends the run
  task automatic wait_loss(input logic v);
    for (int i = 0; i < 100 && loss !== v; i++) cyc(1);
    if (loss !== v) begin
      fails++;
      $display("ERROR loss wait exp %0h got %0h", v, loss);
      results();
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // osc stops; a single edge in mid-count must restart the count
  task automatic t_loss(input logic sw, input bit glitch);
    logic [7:0] f0;
    f0 = nf;
    en = sw;
    osc_on = 1'b0;
    cyc(60);
    `CHK("early loss", 1'b0, loss)
    if (glitch) begin
      osc = 1'b0; cyc(3); osc = 1'b1; cyc(3); osc = 1'b0;
      cyc(60);
      `CHK("restart", 1'b0, loss)
    end
    wait_loss(1'b1);
    `CHK("error pin", 1'b0, errn)
    `CHK("ref select", sw, refrc)
    cyc(2);
    `CHK("pmic saw", f0 + 8'h01, nf)
    osc_on = 1'b1;
    wait_loss(1'b0);
    `CHK("error clear", 1'b1, errn)
    `CHK("ref back", 1'b0, refrc)
  endtask
  // one source at a time: its own output divides by four, the other's edge count falls outside that range
  task automatic t_div();
    int a, b;
    logic pd, pm;
    for (int p = 0; p < 2; p++) begin
      sys_on = (p == 0); mcu_on = (p == 1); a = 0; b = 0; pd = dv; pm = mdv;
      repeat (512) begin cyc(1); a += (dv && !pd); b += (mdv && !pm); pd = dv; pm = mdv; end
      `CHK("sys div", p == 0, a >= 15 && a <= 17)
      `CHK("mcu div", p == 1, b >= 15 && b <= 17)
    end
  endtask
  // static one-hot source levels reveal each select code
  task automatic t_obs();
    osc_on = 0; rc_on = 0; sys_on = 0; mcu_on = 0;
    for (int s = 0; s < 4; s++) begin
      {mcuc, sysc, rc, osc} = 4'h1 << s;
      for (int k = 0; k < 4; k++) begin
        sa = 2'(k); sb = 2'(3 - k); sm = 2'(k);
        cyc(5);
        `CHK("obs a", s == k, oa)
        `CHK("obs b", s == 3 - k, ob)
        `CHK("obs mcu", s == k, om)
      end
    end
    osc_on = 1; rc_on = 1; sys_on = 1; mcu_on = 1;
  endtask
  task automatic t_per();
    int hi;
    per_on = 1;
    for (int g = 0; g < 2; g++) begin
      pra = g[0]; cyc(5); hi = 0;
      repeat (40) begin cyc(1); hi += (po === 1'b1); end
      `CHK("periph out", g == 1, hi > 5 && hi < 35)
    end
  endtask

  initial begin
    nrst = 1'b0; osc = 0; rc = 0; sysc = 0; mcuc = 0; per = 0; en = 0; pra = 0;
    sa = 2'h0; sb = 2'h0; sm = 2'h0;
    osc_on = 1; rc_on = 1; sys_on = 1; mcu_on = 1; per_on = 0;
    cyc(5);
    nrst = 1'b1;
    cyc(10);
    `CHK("error idle", 1'b1, errn)
    t_loss(1'b1, 1'b0);
    t_loss(1'b0, 1'b1);
    t_div();
    t_obs();
    t_per();
    results();
  end
endmodule
`default_nettype wire
